// >>> rtl/pif_flags.v
// peripheral interrupt flag register with AXI4-Lite slave
`timescale 1ns/1ps
`include "pif_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// [R1] The flag register sits at address 0x0c and all its bits clear at reset.
// [R2] Bit 7 sets on each completed parallel port access and holds until software clears it.
// [R3] Bit 5 mirrors a full receive buffer, clears when the receive data is read, and is read-only; the code holds rx_data_read low.
// [R4] Bit 4 mirrors an empty transmit buffer, clears when transmit data is written, and is read-only; the code holds tx_data_write low.
// [R5] Bit 3 sets when a synchronous serial transfer completes and holds until software clears it.
// [R6] Bit 2 sets on a timer-one capture in capture mode and holds until software clears it.
// [R7] Bit 2 sets on a timer-one compare match in compare mode and holds until software clears it.
// [R8] Bit 1 sets when the timer-two count equals its period and holds until software clears it.
// [R9] Bit 0 sets on a sixteen-bit timer-one overflow and holds until software clears it.
// [R10] Flags set regardless of any enable; enables only gate requests.
// [R11] Software should clear a pending flag before setting its enable.
// [R12] The second enable register holds the capture/compare unit two enable.
// [R13] Bit 6 is a plain read/write bit that no hardware sets.
// [R14] A hardware set beats a software clear in the same cycle.
module pif_flags #(
  parameter ADDR_W = 8
) (
  // clock, reset, enable
  input  wire              aclk,
  input  wire              aresetn,
  input  wire              clk_en,
  // axi4-lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // axi4-lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // peripheral events, one-cycle pulses
  input  wire              psp_access_done,
  input  wire              ssp_xfer_done,
  input  wire              capcomp_unit_one_capture_evt,
  input  wire              capcomp_unit_one_compare_evt,
  input  wire [1:0]        capcomp_unit_one_mode,
  input  wire              timer_two_count_period_match,
  input  wire              timer_one_count_overflow,
  // serial buffer levels
  input  wire              rx_buffer_full,
  input  wire              tx_buffer_empty,
  // serial data register access strobes
  output reg               rx_data_read,
  output reg               tx_data_write,
  // flag and enable views
  output reg  [7:0]        flags_out,
  output wire              capcomp_two_enable
);

  localparam MODE_CAPTURE = 2'b01;
  localparam MODE_COMPARE = 2'b10;

  reg  [7:0]        flags_r;
  reg  [7:0]        enables_two_r;
  reg  [ADDR_W-1:0] awaddr_r;
  reg               aw_held_r;
  reg  [31:0]       wdata_r;
  reg  [3:0]        wstrb_r;
  reg               w_held_r;
  reg  [7:0]        hw_set;
  reg  [7:0]        sw_clr;
  reg  [7:0]        sw_set;
  reg  [7:0]        flags_nxt;
  wire              wr_go;
  wire              wr_flags;
  wire              wr_en2;
  wire              rd_go;
  wire [ADDR_W-1:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
  assign wr_go         = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign wr_flags      = wr_go && ({awaddr_r[ADDR_W-1:`PIF_ADDR_LSB], 2'b00} == `PIF_FLAGS_ONE_ADDR)
                         && wstrb_r[0]; // [R1]
  assign wr_en2        = wr_go && ({awaddr_r[ADDR_W-1:`PIF_ADDR_LSB], 2'b00} == `PIF_ENABLES_TWO_ADDR)
                         && wstrb_r[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      awaddr_r     <= {ADDR_W{1'b0}};
      wdata_r      <= 32'h00000000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PIF_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (({awaddr_r[ADDR_W-1:`PIF_ADDR_LSB], 2'b00} == `PIF_FLAGS_ONE_ADDR) ||
                         ({awaddr_r[ADDR_W-1:`PIF_ADDR_LSB], 2'b00} == `PIF_ENABLES_TWO_ADDR)) ?
                        `PIF_RESP_OKAY : `PIF_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read channel
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_go         = s_axi_arvalid & s_axi_arready;
  assign rd_word       = {s_axi_araddr[ADDR_W-1:`PIF_ADDR_LSB], 2'b00};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `PIF_RESP_OKAY;
    end else if (clk_en) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `PIF_RESP_OKAY;
        if (rd_word == `PIF_FLAGS_ONE_ADDR)
          s_axi_rdata <= {24'h000000, flags_r};
        else if (rd_word == `PIF_ENABLES_TWO_ADDR)
          s_axi_rdata <= {24'h000000, enables_two_r}; // [R12]
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `PIF_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flag update
  always @* begin
    hw_set = 8'h00;
    // events set flags with no enable in the path
    hw_set[`PIF_BIT_PSP]  = psp_access_done; // [R2] [R10]
    hw_set[`PIF_BIT_SSP]  = ssp_xfer_done; // [R5]
    hw_set[`PIF_BIT_CAPCOMP_UNIT_ONE] = ((capcomp_unit_one_mode == MODE_CAPTURE) && capcomp_unit_one_capture_evt) || // [R6]
                            ((capcomp_unit_one_mode == MODE_COMPARE) && capcomp_unit_one_compare_evt); // [R7]
    hw_set[`PIF_BIT_TIMER_TWO_COUNT] = timer_two_count_period_match; // [R8]
    hw_set[`PIF_BIT_TIMER_ONE_COUNT] = timer_one_count_overflow; // [R9]
    sw_clr = 8'h00;
    sw_set = 8'h00;
    if (wr_flags) begin
      sw_clr = ~wdata_r[7:0] & `PIF_SW_MASK; // [R13]
      sw_set = wdata_r[7:0] & `PIF_SW_MASK;
    end
    flags_nxt = ((flags_r & ~sw_clr) | sw_set | hw_set) & `PIF_SW_MASK; // [R14]
    flags_nxt[`PIF_BIT_RXFULL]  = rx_buffer_full; // [R3]
    flags_nxt[`PIF_BIT_TXEMPTY] = tx_buffer_empty; // [R4]
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      flags_r       <= `PIF_FLAGS_RESET; // [R1]
      enables_two_r <= `PIF_ENABLES_RESET;
      rx_data_read  <= 1'b0;
      tx_data_write <= 1'b0;
      flags_out     <= `PIF_FLAGS_RESET;
    end else if (clk_en) begin
      flags_r   <= flags_nxt;
      flags_out <= flags_nxt;
      if (wr_en2)
        enables_two_r <= {7'h00, wdata_r[`PIF_BIT_CCP2EN]}; // [R12]
      // strobes are held low; nothing here tells the serial port to drain / load its buffer
      rx_data_read  <= 1'b0; // [R3]
      tx_data_write <= 1'b0; // [R4]
    end
  end

  assign capcomp_two_enable = enables_two_r[`PIF_BIT_CCP2EN]; // [R12]

endmodule // pif_flags

// >>> rtl/pif_regs.vh
// register offsets, bit positions and reset values of the peripheral flag block
`ifndef PIF_REGS_VH
`define PIF_REGS_VH
`define PIF_FLAGS_ONE_ADDR   8'h0c
`define PIF_ENABLES_TWO_ADDR 8'h8c
`define PIF_BIT_PSP          7
`define PIF_BIT_RSVD         6
`define PIF_BIT_RXFULL       5
`define PIF_BIT_TXEMPTY      4
`define PIF_BIT_SSP          3
`define PIF_BIT_CAPCOMP_UNIT_ONE         2
`define PIF_BIT_TIMER_TWO_COUNT         1
`define PIF_BIT_TIMER_ONE_COUNT         0
`define PIF_BIT_CCP2EN       0
`define PIF_FLAGS_RESET      8'h00
`define PIF_ENABLES_RESET    8'h00
`define PIF_SW_MASK          8'hcf
`define PIF_RESP_OKAY        2'b00
`define PIF_RESP_SLVERR      2'b10
`define PIF_ADDR_LSB         2
`endif

// >>> verification/pif_flags_checker.sv
// assertions on the flag register ports
`timescale 1ns/1ps
module pif_flags_checker (
  // clock, reset
  input wire       aclk,
  input wire       aresetn,
  input wire       clk_en,
  // bus answers
  input wire       s_axi_bvalid,
  input wire       s_axi_rvalid,
  // events and levels
  input wire       psp_access_done,
  input wire       ssp_xfer_done,
  input wire       capcomp_unit_one_capture_evt,
  input wire       capcomp_unit_one_compare_evt,
  input wire [1:0] capcomp_unit_one_mode,
  input wire       timer_two_count_period_match,
  input wire       timer_one_count_overflow,
  input wire       rx_buffer_full,
  input wire       tx_buffer_empty,
  // flag view
  input wire [7:0] flags_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  psp_set_a: assert property (psp_access_done && clk_en |=> flags_out[7]) else $error("psp flag");
  ssp_set_a: assert property (ssp_xfer_done && clk_en |=> flags_out[3]) else $error("ssp flag");
  cap_set_a: assert property (capcomp_unit_one_capture_evt && capcomp_unit_one_mode == 2'b01 && clk_en |=> flags_out[2]) else $error("cap");
  cmp_set_a: assert property (capcomp_unit_one_compare_evt && capcomp_unit_one_mode == 2'b10 && clk_en |=> flags_out[2]) else $error("cmp");
  timer_two_count_set_a: assert property (timer_two_count_period_match && clk_en |=> flags_out[1]) else $error("timer_two_count flag");
  timer_one_count_set_a: assert property (timer_one_count_overflow && clk_en |=> flags_out[0]) else $error("timer_one_count flag");
  rx_mirror_a: assert property (clk_en |=> flags_out[5] == $past(rx_buffer_full)) else $error("rx mirror");
  tx_mirror_a: assert property (clk_en |=> flags_out[4] == $past(tx_buffer_empty)) else $error("tx mirror");
  reset_clear_a: assert property (disable iff (1'b0) !aresetn && clk_en |=> flags_out == 8'h00 && !s_axi_bvalid
                                  && !s_axi_rvalid) else $error("reset value");
  cover property (psp_access_done);
  cover property (capcomp_unit_one_compare_evt && capcomp_unit_one_mode == 2'b10);
  cover property (s_axi_bvalid);
endmodule // pif_flags_checker
bind pif_flags pif_flags_checker chk (.*);

// >>> verification/tb_top.sv
// self-checking bench of the peripheral flag register
`timescale 1ns/1ps
`include "pif_regs.vh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
  logic        aclk = 0, aresetn = 0, clk_en = 1, rx_buffer_full = 0, tx_buffer_empty = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, flags_out;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rx_data_read, tx_data_write, capcomp_two_enable;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, capcomp_unit_one_mode = 0;
  logic [5:0]  ev = 0;
  wire         timer_one_count_overflow = ev[0], timer_two_count_period_match = ev[1], capcomp_unit_one_capture_evt = ev[2];
  wire         capcomp_unit_one_compare_evt = ev[3], ssp_xfer_done = ev[4], psp_access_done = ev[5];
  int          bad_count = 0, tests_run = 0, cyc = 0, pos[6] = '{0, 1, 2, 2, 3, 7};
  always #12.5 aclk = ~aclk;
  pif_flags uut (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("counts: bad %0d of %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      complete_run();
    end
  end
  task wr(input [7:0] a, input [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      // sample the pre-edge values at the handshake edge itself
      @(posedge aclk);
      ta = s_axi_awready & s_axi_awvalid;
      tw = s_axi_wready & s_axi_wvalid;
      tb = s_axi_bvalid & s_axi_bready;
      r = s_axi_bresp;
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end while (!tb);
    s_axi_bready <= 0;
  endtask
  task rd(input [7:0] a);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      ta = s_axi_arready & s_axi_arvalid;
      tr = s_axi_rvalid & s_axi_rready;
      q = s_axi_rdata;
      r = s_axi_rresp;
      if (ta) s_axi_arvalid <= 0;
    end while (!tr);
    s_axi_rready <= 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_events;
    for (int i = 0; i < 7; i++) begin
      @(posedge aclk);
      capcomp_unit_one_mode <= (i == 3) ? 2'b10 : (i == 6) ? 2'b00 : 2'b01;
      ev <= (i == 6) ? 6'h04 : 6'h01 << i;
      @(posedge aclk);
      ev <= 0;
      rd(`PIF_FLAGS_ONE_ADDR);
      `CHK("event flag", (i == 6) ? 32'h0 : 32'h1 << pos[i], q)
      `CHK("flag view", q[7:0], flags_out)
      wr(`PIF_FLAGS_ONE_ADDR, 0);
    end
  endtask
  task t_levels;
    rx_buffer_full <= 1;
    wr(`PIF_FLAGS_ONE_ADDR, 0);
    rd(`PIF_FLAGS_ONE_ADDR);
    `CHK("rx full", 32'h20, q)
    `CHK("strobes idle", 2'b00, {rx_data_read, tx_data_write})
    rx_buffer_full <= 0;
    tx_buffer_empty <= 1;
    wr(`PIF_FLAGS_ONE_ADDR, 32'h40);
    rd(`PIF_FLAGS_ONE_ADDR);
    `CHK("tx empty, spare", 32'h50, q)
    tx_buffer_empty <= 0;
    // event pulse lands on the edge at which the clearing write is applied
    fork
      wr(`PIF_FLAGS_ONE_ADDR, 0);
      begin
        @(posedge aclk);
        @(posedge aclk);
        ev <= 6'h01;
        @(posedge aclk);
        ev <= 0;
      end
    join
    rd(`PIF_FLAGS_ONE_ADDR);
    `CHK("set beats clear", 32'h01, q)
  endtask
  task t_freeze;
    wr(`PIF_FLAGS_ONE_ADDR, 0);
    @(posedge aclk);
    clk_en <= 0;
    ev <= 6'h01;
    @(posedge aclk);
    ev <= 0;
    @(posedge aclk);
    clk_en <= 1;
    rd(`PIF_FLAGS_ONE_ADDR);
    `CHK("frozen event", 32'h0, q)
  endtask
  task t_map;
    wr(`PIF_FLAGS_ONE_ADDR, 0);
    wr(`PIF_ENABLES_TWO_ADDR, 1);
    `CHK("en2 resp", `PIF_RESP_OKAY, r)
    `CHK("capcomp_unit_two enable", 1'b1, capcomp_two_enable)
    wr(8'h20, 32'hff);
    `CHK("unmapped wr", `PIF_RESP_SLVERR, r)
    rd(8'h20);
    `CHK("unmapped rd", `PIF_RESP_SLVERR, r)
    `CHK("unmapped data", 32'h0, q)
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(`PIF_FLAGS_ONE_ADDR);
    `CHK("reset flags", 32'h0, q)
    rd(`PIF_ENABLES_TWO_ADDR);
    `CHK("reset en2", 32'h0, q)
    t_events();
    t_levels();
    t_freeze();
    t_map();
    complete_run();
  end
endmodule // tb_top
